// [shared/gate_cmd_pkg.sv]
// constants, field layouts and the parity function shared by both ends of the serial command link
package gate_cmd_pkg;
   // ==========================================================
   // frame layout
   localparam int FRAME_BITS = 32;
   localparam int CODE_MSB = 31;
   localparam int CODE_LSB = 28;
   localparam int ACCESS_BIT = 27;
   localparam int PARITY_BIT = 0;
   localparam logic [3:0] CODE_GLOBAL = 4'h0;
   localparam logic [3:0] CODE_PULSE = 4'h9;
   localparam logic [3:0] CODE_SELFTEST = 4'hA;
   // pulse frame fields
   localparam logic [9:0] PULSE_FILL = 10'h155;
   localparam int PULSE_FILL_MSB = 26;
   localparam int PULSE_FILL_LSB = 17;
   localparam int OFF_PULSE_MSB = 16;
   localparam int OFF_PULSE_LSB = 9;
   localparam int ON_PULSE_MSB = 8;
   localparam int ON_PULSE_LSB = 1;
   // self-test frame fields
   localparam logic [19:0] SELFTEST_FILL = 20'h55555;
   localparam int SELFTEST_FILL_MSB = 26;
   localparam int SELFTEST_FILL_LSB = 7;
   localparam int SELFTEST_REQ_MSB = 6;
   localparam int SELFTEST_REQ_LSB = 5;
   localparam int WATCHDOG_SEL_MSB = 4;
   localparam int WATCHDOG_SEL_LSB = 3;
   localparam int TAIL_FILL_MSB = 2;
   localparam int TAIL_FILL_LSB = 1;
   localparam logic [1:0] TAIL_FILL = 2'h2;
   localparam logic [1:0] SELFTEST_REQUEST = 2'h1;
   localparam logic [1:0] WATCHDOG_ON = 2'h1;
   localparam logic [1:0] WATCHDOG_OFF = 2'h2;
   // global readback fields
   localparam int SPREAD_BIT = 26;
   localparam int DIAG_EN_BIT = 25;
   localparam int SOURCE_MSB = 24;
   localparam int SOURCE_LSB = 17;
   localparam int FORCE_OFF_MSB = 16;
   localparam int FORCE_OFF_LSB = 9;
   localparam int LEVEL_MSB = 8;
   localparam int LEVEL_LSB = 1;
   // fixed request frames
   localparam logic [31:0] FRAME_INTEGRITY_LO = 32'hBAAAAAAA;
   localparam logic [31:0] FRAME_INTEGRITY_HI = 32'hCAAAAAAB;
   localparam logic [31:0] FRAME_STATUS = 32'hDAAAAAAA;
   // ==========================================================
   // master register map (apb byte offsets)
   localparam logic [11:0] REG_TX_FRAME = 12'h000;
   localparam logic [11:0] REG_CONTROL = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_RX_FRAME = 12'h00C;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_AUTOPAR_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_PERR_BIT = 2;
   // link clock divider: half period in pclk cycles
   localparam logic [3:0] SCK_HALF = 4'h2;
   localparam logic [5:0] BIT_COUNT_LAST = 6'h1F;
   // ==========================================================
   // parity: 1 when bits 31..1 hold an even count of ones
   function automatic logic frame_parity(input logic [31:0] f);
      frame_parity = ~(^f[31:1]);
   endfunction
endpackage

// [shared/gate_link_if.sv]
// serial command link between the controller and the gate pre-driver
`timescale 1ns/1ps
interface gate_link_if;
   logic sck; // link clock, made by the controller
   logic cs_n; // frame select, low for a frame
   logic mosi; // controller to device data
   logic miso; // device to controller data
   // controller end
   modport ctrl (output sck, output cs_n, output mosi, input miso);
   // device end
   modport dev (input sck, input cs_n, input mosi, output miso);
endinterface

// [verilog/gate_frame_device.sv]
// device end: shifts command frames, decodes them, returns the global readback
`timescale 1ns/1ps
// Function
// [RULE_01] pulse frame: code 1001, filler 0101010101
// [RULE_02] bit 27: write-and-read or read only
// [RULE_03] self-test frame: code 1010, fixed fillers
// [RULE_04] bits 16..9 request channel off pulses
// [RULE_05] bits 8..1 request channel on pulses
// [RULE_06] self-test starts only on field 01
// [RULE_07] watchdog field: 01 on, 10 off
// [RULE_08] bit 0 is even parity over 31..1
// [RULE_09] fixed frame asks channels 1-4 integrity
// [RULE_10] fixed frame asks channels 5-8 integrity
// [RULE_11] fixed frame asks status and monitors
// [RULE_12] response 0 field order as documented
// [RULE_13] diagnostic enable low means none diagnosed
// [RULE_14] source bit: pin or serial drive
// [RULE_15] force-off bit holds channel off
// [RULE_16] spread bit enables spread spectrum
// [RULE_17] act only after full 32-bit frame
module gate_frame_device
(
   // system clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   gate_link_if.dev link,
   // channel pins and levels
   input wire logic [7:0] channel_control_pin,
   input wire logic [7:0] serial_drive,
   input wire logic [7:0] output_level,
   // decoded results
   output logic [7:0] channel_on,
   output logic [7:0] channel_diag_active,
   output logic [7:0] off_pulse_req,
   output logic [7:0] on_pulse_req,
   output logic self_test_request,
   output logic communication_watchdog,
   output logic spread_spectrum,
   output logic [3:0] fixed_request,
   output logic frame_error
);
   import gate_cmd_pkg::*;

   // ==========================================================
   // link domain: shift register on the link clock
   typedef struct packed
   {
      logic [31:0] shift; // incoming bits
      logic [31:0] done_word; // last complete frame
      logic done_tog; // toggles per complete frame
   } link_state_t;
   // per-frame state, cleared while the select is high
   typedef struct packed
   {
      logic [5:0] count; // bits taken in this frame
      logic [31:0] resp; // outgoing frame, next bit on top
   } frame_state_t;
   link_state_t ls;
   link_state_t next_ls;
   frame_state_t fs;
   frame_state_t next_fs;
   logic frame_rst_n; // low outside frames: the link clock is still then
   logic [31:0] reply_word; // response from pclk domain, updated after each decode and with output_level

   // counter must restart without a link clock edge, so the select clears it
   assign frame_rst_n = presetn & ~link.cs_n;
   // bit 31 has to stand before the first rise, so it comes straight from reply_word
   assign link.miso = (fs.count == 6'h00) ? reply_word[31] : fs.resp[31];

   // next link state
   always_comb
   begin
      next_ls = ls;
      next_fs = fs;
      next_ls.shift = {ls.shift[30:0], link.mosi};
      if (fs.count == 6'h00)
      begin
         // first rise: bit 31 is out, bring bit 30 up
         next_fs.resp = {reply_word[30:0], 1'b0};
      end
      else
      begin
         next_fs.resp = {fs.resp[30:0], 1'b0};
      end
      if (fs.count != 6'h20)
      begin
         next_fs.count = fs.count + 6'h01;
      end
      if (fs.count == BIT_COUNT_LAST)
      begin
         // latch full frame only when 32 bits are in
         next_ls.done_word = {ls.shift[30:0], link.mosi}; // RULE_17
         next_ls.done_tog = ~ls.done_tog;
      end
   end

   // link registers that live across frames
   always_ff @(posedge link.sck or negedge presetn)
   begin
      if (!presetn)
      begin
         ls <= '0;
      end
      else
      begin
         ls <= next_ls;
      end
   end

   // frame registers; restart with each frame select
   always_ff @(posedge link.sck or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         fs <= '0;
      end
      else
      begin
         fs <= next_fs;
      end
   end

   // ==========================================================
   // pclk domain: decode
   typedef struct packed
   {
      logic [2:0] tog_sync; // toggle synchroniser, bit 0 first stage
      logic [31:0] frame; // frame captured after crossing
      logic access; // last access bit
      logic spread; // spread spectrum enable
      logic diag_en; // diagnostics enable
      logic [7:0] source; // per-channel drive source
      logic [7:0] force_off; // per-channel force off
      logic [7:0] off_pulse;
      logic [7:0] on_pulse;
      logic selftest;
      logic watchdog;
      logic [3:0] fixed_req;
      logic ferr;
      logic [7:0] chan_on;
      logic [7:0] diag_act;
      logic [31:0] reply;
      logic [7:0] pin_s1; // pin synchroniser, first stage
      logic [7:0] pin_s2; // second stage
      logic [7:0] pin_s3; // third stage
      logic [7:0] pin_q; // pin level once stages two and three agree
   } core_state_t;
   core_state_t cs;
   core_state_t next_cs;

   // reply follows the decoded fields and output_level, one pclk cycle late
   assign reply_word = cs.reply;
   logic [31:0] w; // word under decode
   logic new_frame;

   // decode and response build
   always_comb
   begin
      next_cs = cs;
      next_cs.tog_sync = {cs.tog_sync[1:0], ls.done_tog};
      // control pins come from outside: three stages, accept on agreement
      next_cs.pin_s1 = channel_control_pin;
      next_cs.pin_s2 = cs.pin_s1;
      next_cs.pin_s3 = cs.pin_s2;
      next_cs.pin_q = (cs.pin_s2 & ~(cs.pin_s2 ^ cs.pin_s3))
                      | (cs.pin_q & (cs.pin_s2 ^ cs.pin_s3));
      new_frame = cs.tog_sync[2] != cs.tog_sync[1];
      w = ls.done_word; // changes with the toggle, so stable once the toggle has settled
      next_cs.off_pulse = '0;
      next_cs.on_pulse = '0;
      next_cs.selftest = 1'b0;
      next_cs.fixed_req = '0;
      if (new_frame)
      begin
         next_cs.frame = w;
         next_cs.access = w[ACCESS_BIT]; // RULE_02
         next_cs.ferr = 1'b0;
         if (w[PARITY_BIT] != frame_parity(w)) // RULE_08
         begin
            next_cs.ferr = 1'b1;
         end
         else if (w == FRAME_INTEGRITY_LO) // RULE_09
         begin
            next_cs.fixed_req = 4'h1;
         end
         else if (w == FRAME_INTEGRITY_HI) // RULE_10
         begin
            next_cs.fixed_req = 4'h2;
         end
         else if (w == FRAME_STATUS) // RULE_11
         begin
            next_cs.fixed_req = 4'h4;
         end
         else if (w[CODE_MSB:CODE_LSB] == CODE_PULSE) // RULE_01
         begin
            if (w[PULSE_FILL_MSB:PULSE_FILL_LSB] != PULSE_FILL)
            begin
               next_cs.ferr = 1'b1;
            end
            else if (!w[ACCESS_BIT])
            begin
               next_cs.off_pulse = w[OFF_PULSE_MSB:OFF_PULSE_LSB]; // RULE_04
               next_cs.on_pulse = w[ON_PULSE_MSB:ON_PULSE_LSB]; // RULE_05
            end
         end
         else if (w[CODE_MSB:CODE_LSB] == CODE_SELFTEST) // RULE_03
         begin
            if (w[SELFTEST_FILL_MSB:SELFTEST_FILL_LSB] != SELFTEST_FILL
                || w[TAIL_FILL_MSB:TAIL_FILL_LSB] != TAIL_FILL)
            begin
               next_cs.ferr = 1'b1;
            end
            else if (!w[ACCESS_BIT])
            begin
               // only 01 starts the sequence
               next_cs.selftest =
                  w[SELFTEST_REQ_MSB:SELFTEST_REQ_LSB] == SELFTEST_REQUEST; // RULE_06
               if (w[WATCHDOG_SEL_MSB:WATCHDOG_SEL_LSB] == WATCHDOG_ON)
               begin
                  next_cs.watchdog = 1'b1; // RULE_07
               end
               else if (w[WATCHDOG_SEL_MSB:WATCHDOG_SEL_LSB] == WATCHDOG_OFF)
               begin
                  next_cs.watchdog = 1'b0; // RULE_07
               end
            end
         end
         else if (w[CODE_MSB:CODE_LSB] == CODE_GLOBAL && !w[ACCESS_BIT])
         begin
            next_cs.spread = w[SPREAD_BIT]; // RULE_16
            next_cs.diag_en = w[DIAG_EN_BIT];
            next_cs.source = w[SOURCE_MSB:SOURCE_LSB];
            next_cs.force_off = w[FORCE_OFF_MSB:FORCE_OFF_LSB];
         end
      end
      // channel drive: source select then forced off
      for (int i = 0; i < 8; i++)
      begin
         next_cs.chan_on[i] = ~cs.force_off[i] // RULE_15
            & (cs.source[i] ? serial_drive[i] : ~cs.pin_q[i]); // RULE_14
      end
      next_cs.diag_act = {8{cs.diag_en}}; // RULE_13
      // global readback in documented field order
      next_cs.reply = {CODE_GLOBAL, cs.access, cs.spread, cs.diag_en,
                       cs.source, cs.force_off, output_level, 1'b0}; // RULE_12
      next_cs.reply[PARITY_BIT] = frame_parity(next_cs.reply); // RULE_08
   end

   // core registers; access bit resets to read-only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cs <= '0;
         cs.access <= 1'b1;
      end
      else
      begin
         cs <= next_cs;
      end
   end

   // outputs
   assign channel_on = cs.chan_on;
   assign channel_diag_active = cs.diag_act;
   assign off_pulse_req = cs.off_pulse;
   assign on_pulse_req = cs.on_pulse;
   assign self_test_request = cs.selftest;
   assign communication_watchdog = cs.watchdog;
   assign spread_spectrum = cs.spread;
   assign fixed_request = cs.fixed_req;
   assign frame_error = cs.ferr;
endmodule // gate_frame_device

// [verilog/gate_frame_master.sv]
// controller end: apb registers drive one 32-bit frame on the link
`timescale 1ns/1ps
module gate_frame_master
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   gate_link_if.ctrl link
);
   import gate_cmd_pkg::*;

   // ==========================================================
   // state
   typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01, FINISH = 2'b10} phase_t;
   typedef struct packed
   {
      phase_t phase;
      logic [31:0] tx; // frame to send
      logic [31:0] rx; // frame received
      logic [31:0] sh; // shift register
      logic autopar; // fill parity on send
      logic done;
      logic perr;
      logic [3:0] div;
      logic [5:0] bits;
      logic sck;
      logic csn;
      logic [2:0] miso_s; // miso synchroniser
      logic [31:0] rdata;
   } mstate_t;
   mstate_t s;
   mstate_t next_s;
   logic acc;
   logic miso_now;

   // next state
   always_comb
   begin
      next_s = s;
      next_s.miso_s = {s.miso_s[1:0], link.miso};
      miso_now = s.miso_s[2];
      acc = psel && penable;
      next_s.rdata = '0;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            REG_TX_FRAME: next_s.rdata = s.tx;
            REG_CONTROL: next_s.rdata = {30'h0, s.autopar, 1'b0};
            REG_STATUS: next_s.rdata = {29'h0, s.perr, s.done, s.phase != IDLE};
            REG_RX_FRAME: next_s.rdata = s.rx;
            default: next_s.rdata = '0;
         endcase
      end
      if (acc && pwrite && paddr == REG_TX_FRAME)
      begin
         next_s.tx = pwdata;
      end
      unique case (s.phase)
         IDLE:
         begin
            if (acc && pwrite && paddr == REG_CONTROL)
            begin
               next_s.autopar = pwdata[CTRL_AUTOPAR_BIT];
               if (pwdata[CTRL_START_BIT])
               begin
                  next_s.sh = s.tx;
                  if (pwdata[CTRL_AUTOPAR_BIT])
                  begin
                     next_s.sh[PARITY_BIT] = frame_parity(s.tx); // RULE_08
                  end
                  next_s.phase = SHIFT;
                  next_s.csn = 1'b0;
                  next_s.done = 1'b0;
                  next_s.div = '0;
                  next_s.bits = '0;
               end
            end
         end
         SHIFT:
         begin
            next_s.div = s.div + 4'h1;
            if (s.div == SCK_HALF - 4'h1)
            begin
               next_s.div = '0;
               next_s.sck = ~s.sck;
               if (s.sck)
               begin
                  // falling edge: advance to next bit
                  next_s.sh = {s.sh[30:0], miso_now};
                  next_s.bits = s.bits + 6'h01;
                  if (s.bits == BIT_COUNT_LAST)
                  begin
                     next_s.phase = FINISH;
                  end
               end
            end
         end
         FINISH:
         begin
            next_s.csn = 1'b1;
            next_s.rx = s.sh;
            next_s.done = 1'b1;
            next_s.perr = s.sh[PARITY_BIT] != frame_parity(s.sh);
            next_s.phase = IDLE;
         end
         default: next_s.phase = IDLE;
      endcase
   end

   // registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.csn <= 1'b1;
         s.phase <= IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs
   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign link.sck = s.sck;
   assign link.cs_n = s.csn;
   assign link.mosi = s.sh[31];
endmodule // gate_frame_master

// [verification/gate_link_asserts.sv]
// concurrent checks on the serial link between controller and device
`timescale 1ns/1ps
module gate_link_asserts
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link signals
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   // =====
   // helper counters
   localparam int LEN_MIN = 126;
   localparam int LEN_MAX = 200;
   logic sck_q; // sck one cycle back
   logic [7:0] bits; // sck rises seen in this frame
   logic [8:0] span; // pclk cycles with the frame open
   // count rises and frame length, cleared while idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_q <= 1'b0;
         bits <= 8'h00;
         span <= 9'h000;
      end
      else
      begin
         sck_q <= sck;
         bits <= cs_n ? 8'h00 : bits + {7'h00, sck & ~sck_q};
         span <= cs_n ? 9'h000 : span + 9'h001;
      end
   end
   // =====
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_high;
      sck ##1 !sck;
   endsequence
   sequence s_first_rise;
      !sck ##[1:8] $rose(sck);
   endsequence
   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   property p_sck_high;
      $rose(sck) |=> s_high;
   endproperty
   property p_sck_low;
      ($fell(sck) && !cs_n) |=> !sck;
   endproperty
   property p_frame_bits;
      $rose(cs_n) |-> bits == 8'd32;
   endproperty
   property p_no_overrun;
      !cs_n |-> bits <= 8'd32;
   endproperty
   property p_first_edge;
      $fell(cs_n) |-> s_first_rise;
   endproperty
   property p_frame_len;
      $rose(cs_n) |-> span inside {[LEN_MIN:LEN_MAX]};
   endproperty
   property p_mosi_stable;
      $rose(sck) |=> $stable(mosi);
   endproperty
   a_sck_idle:
      assert property (p_sck_idle) else $error("link clock runs outside a frame");
   a_sck_high:
      assert property (p_sck_high) else $error("link clock high phase wrong");
   a_sck_low:
      assert property (p_sck_low) else $error("link clock low phase too short");
   a_frame_bits:
      assert property (p_frame_bits) else $error("frame closed without 32 bits");
   a_no_overrun:
      assert property (p_no_overrun) else $error("more than 32 bits in a frame");
   a_first_edge:
      assert property (p_first_edge) else $error("first clock edge late");
   a_frame_len:
      assert property (p_frame_len) else $error("frame length out of range");
   a_mosi_stable:
      assert property (p_mosi_stable) else $error("data moved while clock high");
endmodule // gate_link_asserts

// [verification/tb_top.sv]
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ps
module tb_top;
   import gate_cmd_pkg::*;
   // =====
   // signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mos, r;
   logic [7:0] ch_on, diag, off_p, on_p, off_s, on_s;
   logic st_p, st_s, wdog, spread, ferr;
   logic [3:0] fx_p, fx_s;
   int errors, checks_done;
   gate_link_if link();
   gate_frame_master gate_frame_master_i(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   gate_frame_device gate_frame_device_i(.pclk(pclk), .presetn(presetn), .link(link),
      .channel_control_pin(8'h33), .serial_drive(8'h55), .output_level(8'hC3),
      .channel_on(ch_on), .channel_diag_active(diag), .off_pulse_req(off_p),
      .on_pulse_req(on_p), .self_test_request(st_p), .communication_watchdog(wdog),
      .spread_spectrum(spread), .fixed_request(fx_p), .frame_error(ferr));
   gate_link_asserts gate_link_asserts_i(.pclk(pclk), .presetn(presetn), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // sticky copies of one-cycle pulses
   always @(posedge pclk)
   begin
      off_s <= clr ? 8'h00 : off_s | off_p;
      on_s <= clr ? 8'h00 : on_s | on_p;
      st_s <= clr ? 1'b0 : st_s | st_p;
      fx_s <= clr ? 4'h0 : fx_s | fx_p;
   end
   // frame as seen on the wire, first bit on top
   always @(posedge link.sck)
      if (!link.cs_n)
         mos <= {mos[30:0], link.mosi};
   // =====
   // shared tasks
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // even parity over bits 31..1 into bit 0
   function automatic logic [31:0] pf(input logic [31:0] f);
      pf = {f[31:1], ~^f[31:1]};
   endfunction
   task send(input logic [31:0] f);
      clr <= 1'b1;
      apb(1'b1, 12'h000, f);
      clr <= 1'b0;
      apb(1'b1, 12'h004, 32'h1);
      for (int k = 0; k < 100; k++)
      begin
         apb(1'b0, 12'h008, 32'h0);
         if (r[1:0] === 2'b10)
            break;
      end
      repeat (10) @(posedge pclk);
      chk("wire", f, mos);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // =====
   // scenarios
   task t_global;
      send(pf({4'h0, 1'b0, 1'b1, 1'b1, 8'hA5, 8'h0F, 9'h000}));
      chk("spread", 32'h1, spread);
      chk("diag", 32'hFF, diag);
      chk("chan_on", 32'h40, ch_on);
      send(pf({4'h0, 1'b1, 27'h0}));
      chk("spread_ro", 32'h1, spread);
      apb(1'b0, 12'h00C, 32'h0);
      chk("reply", {6'h0, 1'b1, 1'b1, 8'hA5, 8'h0F, 8'hC3}, r[26:1]);
      chk("reply_code", 32'h0, r[31:28]);
      chk("reply_par", ~^r[31:1], r[0]);
      send(pf(32'h0));
      chk("diag_off", 32'h0, diag);
      chk("spread_off", 32'h0, spread);
      chk("chan_pin", 32'hCC, ch_on);
   endtask
   task t_pulse;
      send(pf({4'h9, 1'b0, 10'h155, 8'h81, 8'h3C, 1'b0}));
      chk("off_pulse", 32'h81, off_s);
      chk("on_pulse", 32'h3C, on_s);
      chk("ferr_ok", 32'h0, ferr);
      send(pf({4'h9, 1'b0, 10'h154, 8'hFF, 8'hFF, 1'b0}));
      chk("fill_off", 32'h0, off_s);
      chk("ferr_fill", 32'h1, ferr);
      send(pf({4'h9, 1'b0, 10'h155, 8'h01, 8'h80, 1'b0}) ^ 32'h1);
      chk("par_on", 32'h0, on_s);
      chk("ferr_par", 32'h1, ferr);
   endtask
   task t_self;
      logic [1:0] wd [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
      for (int i = 0; i < 4; i++)
      begin
         send(pf({4'hA, 1'b0, 20'h55555, 2'(i), wd[i], 2'h2, 1'b0}));
         chk("selftest", 32'(i == 1), st_s);
         chk("watchdog", 32'(i < 2), wdog);
      end
      send(pf({4'hA, 1'b0, 20'h55555, 2'h1, 2'h1, 2'h1, 1'b0}));
      chk("tail_fill", 32'h0, {st_s, wdog});
   endtask
   task t_fixed;
      logic [31:0] fx [3] = '{32'hBAAAAAAA, 32'hCAAAAAAB, 32'hDAAAAAAA};
      for (int i = 0; i < 3; i++)
      begin
         send(fx[i]);
         chk("fixed", 32'h1 << i, fx_s);
      end
   endtask
   task t_apb;
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", 32'h0, r);
      apb(1'b0, 12'h008, 32'h0);
      chk("status", 32'h2, r[2:0]);
      chk("no_slverr", 32'h0, pslverr);
   endtask
   // =====
   // main sequence and watchdog
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      clr = 1'b1;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_global;
      t_pulse;
      t_self;
      t_fixed;
      t_apb;
      print_verdict;
   end
   initial
   begin
      #400us;
      errors++;
      print_verdict;
   end
endmodule // tb_top
